/* File: verilog/atrc_pkg.sv */
// Purpose: constants for the converter reference and touch-plate control block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: offsets and field positions are defined here; the checker and the result word in atrc_top repeat them as literals
//
// Function
// - positive reference select routes ext pin, supply, analog in 0 or 1
// - negative reference select routes ground, analog in 2 or 3
// - single-ended mode ignores the negative reference selection
// - pen detector enabled only with plate drive code 101b
// - pen detector output readable as flag in result register when enabled
// - wake line is pen detector OR conversion done when enabled
// - code 010b drives x plus high, x minus low
// - code 001b drives y plus high, y minus low, x lines released
// - while sampling x, both y lines are released
// - code 100b drives y plus high, x minus low for pen force
// - plus lines only pull high, minus lines only pull low
// - converter may run from auxiliary clock 2 in power saving
// - results unreadable while system clock is suspended
// - conversion started before power saving completes and raises wake
// - emulator halt stops result reads from popping the fifo
// - emulator halt still writes results and may raise done interrupt
// - outside halt, each result read pops one of four entries
// - done interrupt set while fifo not empty, drops one cycle after read
// - wake done input asserted while fifo holds an entry
package atrc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_GLOBAL_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_AUX_CONFIG    = 8'h04;
	localparam logic [7:0] ADDR_RESULT_FIFO   = 8'h08;
	localparam logic [7:0] ADDR_STATUS        = 8'h0c;

	// ----------------------------------------------------------------
	// global and aux config fields
	// ----------------------------------------------------------------
	localparam int GCR_CLKEN      = 0;
	localparam int GCR_DIFF       = 2;
	localparam int GCR_INTEN      = 13;
	localparam int GCR_PREF_LSB   = 9;
	localparam int GCR_NREF_LSB   = 11;
	localparam int GCR_DRIVE_LSB  = 6;
	localparam logic [15:0] GCR_RESET     = 16'h0000;
	localparam logic [15:0] GCR_WRITE_MASK = 16'h3fc7;
	localparam int ACR_CLKSEL     = 0;
	localparam logic [15:0] ACR_RESET     = 16'h0000;

	// ----------------------------------------------------------------
	// result register fields
	// ----------------------------------------------------------------
	localparam int RES_DATA_W     = 12;
	localparam int RES_SIGN       = 12;
	localparam int RES_PEN        = 13;
	localparam int RES_OVF        = 14;
	localparam int RES_DONE       = 15;
	localparam int FIFO_DEPTH     = 4;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		DRV_NONE     = 3'h0,
		DRV_SAMPLE_Y = 3'h1,
		DRV_SAMPLE_X = 3'h2,
		DRV_SAMPLE_Z1 = 3'h3,
		DRV_SAMPLE_Z2 = 3'h4,
		DRV_PEN_DET  = 3'h5
	} atrc_drive_t;

	typedef enum logic [1:0] {
		PREF_SUPPLY = 2'h0,
		PREF_EXT    = 2'h1,
		PREF_AIN0   = 2'h2,
		PREF_AIN1   = 2'h3
	} atrc_pref_t;

	typedef enum logic [1:0] {
		NREF_GROUND = 2'h0,
		NREF_RSVD   = 2'h1,
		NREF_AIN2   = 2'h2,
		NREF_AIN3   = 2'h3
	} atrc_nref_t;

endpackage : atrc_pkg

/* File: verilog/atrc_result_fifo.sv */
// Purpose: result queue on the system clock
// Assumes: push and pop are one-cycle pulses
// Notes: push into a full queue is dropped and flagged
`timescale 1ns/1ns
`default_nettype none
module atrc_result_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	output logic                  not_empty,
	output logic                  overflow
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// pointers wrap by overflow, so only power-of-two depths are served
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             full;
	logic             do_push;
	logic             do_pop;

	assign full      = (cnt_q == (AW+1)'(DEPTH));
	assign not_empty = (cnt_q != '0);
	assign do_push   = push && !full;
	assign do_pop    = pop && not_empty;
	assign head      = mem[rd_q];
	assign overflow  = push && full;

	always_ff @(posedge pclk)
	begin
		if (do_push)
			mem[wr_q] <= push_data;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_push)
				wr_q <= wr_q + 1'b1;
			if (do_pop)
				rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : atrc_result_fifo
`default_nettype wire

/* File: verilog/atrc_top.sv */
// Purpose: reference select, touch-plate drive, pen detect, result path
// Assumes: conversion results arrive as a one-cycle strobe on pclk
// Notes: analog muxes are steered by select outputs; no analog here
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module atrc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        conv_done,
	input  wire logic [12:0] conv_data,
	input  wire logic        pen_detect_in,
	input  wire logic        emu_halt,
	output logic      [1:0]  pos_ref_select,
	output logic      [1:0]  neg_ref_select,
	output logic             neg_ref_used,
	output logic             conv_clk_aux_sel,
	output logic             conv_enable,
	output logic             x_plate_plus_hi,
	output logic             x_plate_plus_weak,
	output logic             x_plate_minus_lo,
	output logic             y_plate_plus_hi,
	output logic             y_plate_minus_lo,
	output logic             pen_detect_en,
	output logic             done_irq,
	output logic             converter_wake_line
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] gcr_q;
	logic [15:0] acr_q;
	logic        ovf_q;
	logic        rd_gap_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire         access   = psel && penable && !pready_q;
	wire         hit_gcr  = (paddr == atrc_pkg::ADDR_GLOBAL_CONFIG);
	wire         hit_acr  = (paddr == atrc_pkg::ADDR_AUX_CONFIG);
	wire         hit_res  = (paddr == atrc_pkg::ADDR_RESULT_FIFO);
	wire         hit_sts  = (paddr == atrc_pkg::ADDR_STATUS);
	wire         mapped   = hit_gcr || hit_acr || hit_res || hit_sts;
	wire         wr_gcr   = access && pwrite && hit_gcr;
	wire         wr_acr   = access && pwrite && hit_acr;
	wire         rd_res   = access && !pwrite && hit_res;

	// fields
	wire  [2:0]  drive    = gcr_q[atrc_pkg::GCR_DRIVE_LSB +: 3];
	wire         diff     = gcr_q[atrc_pkg::GCR_DIFF];
	wire         clken    = gcr_q[atrc_pkg::GCR_CLKEN];
	wire         inten    = gcr_q[atrc_pkg::GCR_INTEN];

	// ----------------------------------------------------------------
	// plate drivers; each output only pulls one way by construction
	// ----------------------------------------------------------------
	wire  code_y   = (drive == atrc_pkg::DRV_SAMPLE_Y);
	wire  code_x   = (drive == atrc_pkg::DRV_SAMPLE_X);
	wire  code_z1  = (drive == atrc_pkg::DRV_SAMPLE_Z1);
	wire  code_z2  = (drive == atrc_pkg::DRV_SAMPLE_Z2);
	wire  code_pen = (drive == atrc_pkg::DRV_PEN_DET);
	// reserved codes match nothing above, so all drivers stay off
	wire  xp_hi_d  = code_x || code_z1;
	wire  xm_lo_d  = code_x || code_z2;
	wire  yp_hi_d  = code_y || code_z2;
	wire  ym_lo_d  = code_y || code_z1 || code_pen;

	// ----------------------------------------------------------------
	// result path
	// ----------------------------------------------------------------
	logic [12:0] fifo_head;
	logic        fifo_nempty;
	logic        fifo_ovf;

	// halt keeps the entry so the emulator can peek without loss
	wire  pop      = rd_res && !emu_halt;
	wire  push     = conv_done && clken;

	atrc_result_fifo #(
		.WIDTH (13),
		.DEPTH (atrc_pkg::FIFO_DEPTH)
	) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.push      (push),
		.push_data (conv_data),
		.pop       (pop),
		.head      (fifo_head),
		.not_empty (fifo_nempty),
		.overflow  (fifo_ovf)
	);

	wire  pen_flag  = code_pen && pen_detect_in;
	// result only reaches the bus through pclk flops, so a halted pclk hides it
	wire  [31:0] res_word = {16'h0000, fifo_nempty, ovf_q, pen_flag,
	                         fifo_head};
	wire  [31:0] sts_word = {28'h0000000, code_pen, fifo_nempty, diff, clken};

	wire  [31:0] rd_mux  = hit_gcr ? {16'h0000, gcr_q} :
	                       hit_acr ? {16'h0000, acr_q} :
	                       hit_res ? res_word :
	                       hit_sts ? sts_word : 32'h00000000;

	// done level, with a one-cycle drop after every result read
	wire  done_lvl  = fifo_nempty && !rd_gap_q;
	wire  irq_d     = done_lvl && inten;
	wire  wake_d    = done_lvl || pen_flag;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gcr_q <= atrc_pkg::GCR_RESET;
			acr_q <= atrc_pkg::ACR_RESET;
		end
		else
		begin
			if (wr_gcr)
				gcr_q <= pwdata[15:0] & atrc_pkg::GCR_WRITE_MASK;
			if (wr_acr)
				acr_q <= {15'h0000, pwdata[atrc_pkg::ACR_CLKSEL]};
		end
	end

	// overflow is sticky; a new overflow in the read cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ovf_q <= 1'b0;
		else if (fifo_ovf && push)
			ovf_q <= 1'b1;
		else if (pop)
			ovf_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_gap_q <= 1'b0;
		else
			rd_gap_q <= rd_res;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= access;
			pslverr_q <= access && !mapped;
			if (access && !pwrite)
				prdata_q <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pos_ref_select      <= 2'h0;
			neg_ref_select      <= 2'h0;
			neg_ref_used        <= 1'b0;
			conv_clk_aux_sel    <= 1'b0;
			conv_enable         <= 1'b0;
			x_plate_plus_hi     <= 1'b0;
			x_plate_plus_weak   <= 1'b0;
			x_plate_minus_lo    <= 1'b0;
			y_plate_plus_hi     <= 1'b0;
			y_plate_minus_lo    <= 1'b0;
			pen_detect_en       <= 1'b0;
			done_irq            <= 1'b0;
			converter_wake_line <= 1'b0;
		end
		else
		begin
			pos_ref_select      <= gcr_q[atrc_pkg::GCR_PREF_LSB +: 2];
			neg_ref_select      <= gcr_q[atrc_pkg::GCR_NREF_LSB +: 2];
			neg_ref_used        <= diff;
			conv_clk_aux_sel    <= acr_q[atrc_pkg::ACR_CLKSEL];
			conv_enable         <= clken;
			x_plate_plus_hi     <= xp_hi_d;
			x_plate_plus_weak   <= code_pen;
			x_plate_minus_lo    <= xm_lo_d;
			y_plate_plus_hi     <= yp_hi_d;
			y_plate_minus_lo    <= ym_lo_d;
			pen_detect_en       <= code_pen;
			done_irq            <= irq_d;
			converter_wake_line <= wake_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

endmodule : atrc_top
`default_nettype wire

/* File: verif/atrc_top_sva.sv */
// Purpose: port checker for the touch and reference control block
// Assumes: outputs lag their cause by one pclk
// Notes: bound into every atrc_top
`timescale 1ns/1ns
`default_nettype none
module atrc_top_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        conv_done,
	input wire logic        pen_detect_in,
	input wire logic        emu_halt,
	input wire logic        neg_ref_used,
	input wire logic        conv_enable,
	input wire logic        x_plate_plus_hi,
	input wire logic        x_plate_plus_weak,
	input wire logic        x_plate_minus_lo,
	input wire logic        y_plate_plus_hi,
	input wire logic        y_plate_minus_lo,
	input wire logic        pen_detect_en,
	input wire logic        done_irq,
	input wire logic        converter_wake_line
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc    = psel && penable && pready;
	wire wr_cfg = acc && pwrite && paddr == 8'h00;
	wire rd_res = acc && !pwrite && paddr == 8'h08;
	property p_pen_drive;
		pen_detect_en |-> x_plate_plus_weak && y_plate_minus_lo && !x_plate_plus_hi
			&& !y_plate_plus_hi && !x_plate_minus_lo;
	endproperty
	a_pen_drive: assert property (p_pen_drive) else $error("pen mode drive wrong");
	property p_pen_on;
		wr_cfg && pwdata[8:6] == 3'h5 |-> ##[0:2] pen_detect_en;
	endproperty
	a_pen_on: assert property (p_pen_on) else $error("pen detect not enabled");
	property p_pen_off;
		wr_cfg && pwdata[8:6] != 3'h5 |-> ##[0:2] !pen_detect_en;
	endproperty
	a_pen_off: assert property (p_pen_off) else $error("pen detect left on");
	property p_x_sample;
		x_plate_plus_hi && x_plate_minus_lo |-> !y_plate_plus_hi && !y_plate_minus_lo;
	endproperty
	a_x_sample: assert property (p_x_sample) else $error("y plate driven in x sample");
	property p_y_sample;
		y_plate_plus_hi && y_plate_minus_lo |-> !x_plate_plus_hi && !x_plate_minus_lo
			&& !x_plate_plus_weak;
	endproperty
	a_y_sample: assert property (p_y_sample) else $error("x plate driven in y sample");
	property p_one_pull;
		!(x_plate_plus_hi && x_plate_plus_weak);
	endproperty
	a_one_pull: assert property (p_one_pull) else $error("strong and weak pull together");
	property p_single;
		wr_cfg && !pwdata[2] |-> ##[0:2] !neg_ref_used;
	endproperty
	a_single: assert property (p_single) else $error("neg reference used single ended");
	property p_wake_pen;
		(pen_detect_en && pen_detect_in) [*3] |-> converter_wake_line;
	endproperty
	a_wake_pen: assert property (p_wake_pen) else $error("pen did not wake");
	property p_read_gap;
		rd_res |-> ##[0:2] !done_irq;
	endproperty
	a_read_gap: assert property (p_read_gap) else $error("no interrupt gap on read");
	property p_done_wake;
		conv_done && conv_enable |-> ##[1:3] converter_wake_line;
	endproperty
	a_done_wake: assert property (p_done_wake) else $error("result did not wake");
	property p_halt_keep;
		rd_res && emu_halt && done_irq |-> ##[2:3] done_irq;
	endproperty
	a_halt_keep: assert property (p_halt_keep) else $error("halted read popped");
	c_pen: cover property (pen_detect_en && converter_wake_line);
	c_halt: cover property (rd_res && emu_halt);
	c_x: cover property (wr_cfg && pwdata[8:6] == 3'h2);
endmodule : atrc_top_sva
bind atrc_top atrc_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .conv_done, .pen_detect_in, .emu_halt, .neg_ref_used, .conv_enable,
	.x_plate_plus_hi, .x_plate_plus_weak, .x_plate_minus_lo, .y_plate_plus_hi,
	.y_plate_minus_lo, .pen_detect_en, .done_irq, .converter_wake_line);
`default_nettype wire

/* File: verif/atrc_touch_model.sv */
// Purpose: four-wire touch panel and converter stand-in
// Assumes: results handed over as one-pclk strobes
// Notes: data lines show the inverse outside a strobe
`timescale 1ns/1ns
`default_nettype none
module atrc_touch_model (
	input  wire logic        pclk,
	input  wire logic        x_plate_plus_weak,
	input  wire logic        y_plate_minus_lo,
	input  wire logic        pen_down,
	output logic             conv_done,
	output logic      [12:0] conv_data,
	output logic             pen_detect_in
);
	// contact reads only through weak pull-up against grounded y plate
	assign pen_detect_in = x_plate_plus_weak & y_plate_minus_lo & pen_down;
	initial
	begin
		conv_done = 1'b0;
		conv_data = 13'h1555;
	end
	task automatic push(input logic [12:0] d);
		@(posedge pclk);
		conv_done <= 1'b1;
		conv_data <= d;
		@(posedge pclk);
		conv_done <= 1'b0;
		conv_data <= ~d;
	endtask : push
endmodule : atrc_touch_model
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: register-level test of the touch and reference control block
// Assumes: apb slave answers whenever pready comes; no latency assumed
// Notes: result and pen paths driven from the panel model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
	logic        emu_halt, pen_down, conv_done, pen_in, nused, aux, en, irq, wake;
	logic        xph, xpw, xml, yph, yml, pen_en;
	logic [1:0]  pref, nref;
	logic [7:0]  paddr;
	logic [12:0] conv_data;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  drv_tab [8];
	int          num_errors, tests_run, cyc;
	atrc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .conv_done, .conv_data, .pen_detect_in(pen_in), .emu_halt,
		.pos_ref_select(pref), .neg_ref_select(nref), .neg_ref_used(nused),
		.conv_clk_aux_sel(aux), .conv_enable(en), .x_plate_plus_hi(xph),
		.x_plate_plus_weak(xpw), .x_plate_minus_lo(xml), .y_plate_plus_hi(yph),
		.y_plate_minus_lo(yml), .pen_detect_en(pen_en), .done_irq(irq),
		.converter_wake_line(wake));
	atrc_touch_model u_touch (.pclk, .x_plate_plus_weak(xpw), .y_plate_minus_lo(yml),
		.pen_down, .conv_done, .conv_data, .pen_detect_in(pen_in));
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	// one transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			num_errors++;
			complete_run;
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, emu_halt, pen_down} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		cyc = 0;
		drv_tab = '{6'h00, 6'h06, 6'h28, 6'h22, 6'h0c, 6'h13, 6'h00, 6'h00};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, atrc_pkg::ADDR_GLOBAL_CONFIG, 32'h0);
		`CHK(rd, 32'h0)
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, atrc_pkg::ADDR_GLOBAL_CONFIG, 32'(c) << atrc_pkg::GCR_DRIVE_LSB);
			repeat (2) @(negedge pclk);
			`CHK({xph, xpw, xml, yph, yml, pen_en}, drv_tab[c])
		end
		$display("test plate drive done");
		for (int p = 0; p < 4; p++)
		begin
			apb(1'b1, atrc_pkg::ADDR_GLOBAL_CONFIG, (32'(p) << atrc_pkg::GCR_PREF_LSB)
				| (32'(p) << atrc_pkg::GCR_NREF_LSB) | (32'(p & 1) << atrc_pkg::GCR_DIFF));
			repeat (2) @(negedge pclk);
			`CHK({pref, nref, nused}, {2'(p), 2'(p), 1'(p & 1)})
		end
		apb(1'b1, atrc_pkg::ADDR_AUX_CONFIG, 32'h1);
		apb(1'b0, atrc_pkg::ADDR_AUX_CONFIG, 32'h0);
		`CHK({rd, aux}, {32'h1, 1'b1})
		$display("test references done");
		emu_halt <= 1'b1;
		apb(1'b1, atrc_pkg::ADDR_GLOBAL_CONFIG, 32'h2001);
		for (int i = 0; i < 5; i++)
			u_touch.push(13'h100 + 13'(i));
		repeat (2) @(negedge pclk);
		`CHK({irq, wake, en}, 3'b111)
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b0, atrc_pkg::ADDR_RESULT_FIFO, 32'h0);
			`CHK(rd[14:0], 15'h4100)
		end
		emu_halt <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, atrc_pkg::ADDR_RESULT_FIFO, 32'h0);
			`CHK(rd[12:0], 13'h100 + 13'(i))
		end
		repeat (2) @(negedge pclk);
		`CHK({irq, wake}, 2'b00)
		$display("test result queue done");
		apb(1'b1, atrc_pkg::ADDR_GLOBAL_CONFIG, 32'h1 | (32'h5 << atrc_pkg::GCR_DRIVE_LSB));
		pen_down <= 1'b1;
		repeat (3) @(negedge pclk);
		`CHK(wake, 1'b1)
		apb(1'b0, atrc_pkg::ADDR_RESULT_FIFO, 32'h0);
		`CHK(rd[13], 1'b1)
		apb(1'b0, atrc_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd, 32'h9)
		pen_down <= 1'b0;
		repeat (3) @(negedge pclk);
		`CHK(wake, 1'b0)
		// unmapped offset must answer with a bus error
		apb(1'b0, 8'h10, 32'h0);
		`CHK(err_q, 1'b1)
		// software parks the converter before a low-power entry
		apb(1'b1, atrc_pkg::ADDR_GLOBAL_CONFIG, 32'h0);
		repeat (2) @(negedge pclk);
		`CHK({en, pen_en, wake}, 3'b000)
		$display("test pen and bus error done");
		complete_run;
	end
endmodule : tb
`default_nettype wire
